/* File: src/phy_cfg_pkg.sv */
// Package: register map, field positions, reset values and timing counts
// Assumes a 200 MHz system clock and a classic Wishbone register bus
package phy_cfg_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_BASIC_CTRL = 8'h00;  // Strap-loaded control (index 0h)
  localparam logic [7:0] OFF_PHY_CTRL2  = 8'h7C;  // Mode control (index 1Fh)
  localparam logic [7:0] OFF_STATUS     = 8'h40;  // Sticky event status
  localparam logic [7:0] OFF_MASK       = 8'h44;  // Interrupt mask
  localparam logic [7:0] OFF_STRAP      = 8'h48;  // Captured strap values
  localparam logic [7:0] OFF_TEST       = 8'h4C;  // Test control and link state

  // Field positions
  localparam int BIT_ANEN      = 12;  // Auto-negotiation enable
  localparam int BIT_SPEED     = 13;  // Speed select, 1 = 100 Mbps
  localparam int BIT_CLK50     = 7;   // 1 = 50 MHz reference input mode
  localparam int BIT_LED_LO    = 4;   // LED mode field low bit
  localparam int BIT_NAND      = 0;   // NAND-tree test enable
  localparam int BIT_LINK      = 1;   // Link up control
  localparam int EV_LINK_UP    = 0;   // Event: link came up
  localparam int EV_LINK_DOWN  = 1;   // Event: link went down
  localparam int EV_RX_FRAME   = 2;   // Event: receive frame ended
  localparam int EV_TX_FRAME   = 3;   // Event: transmit frame ended
  localparam int EV_W          = 4;   // Event count

  // Reset and mode values
  localparam logic [1:0] LED_LINK_ACT = 2'h0;  // Combined link/activity
  localparam logic [1:0] LED_LINK     = 2'h1;  // Link only
  localparam logic [4:0] ADDR_UP      = 5'h03; // Address when strap pulled up
  localparam logic [4:0] ADDR_DOWN    = 5'h00; // Address when strap pulled down

  // Timing
  localparam int CLK_MHZ        = 200;
  localparam int BLINK_MS       = 50;   // Activity blink half period
  localparam int BLINK_CYC      = BLINK_MS * CLK_MHZ * 1000;
endpackage

/* File: src/rmii_if.sv */
// Interface: two-bit RMII data lanes between the top and the lane engine
// Assumes both ends sit on the system clock
`timescale 1ns/1ps
interface rmii_if;
  logic       ref_rise;  // One-cycle pulse on reference rising edge
  logic       txen;      // Synchronised transmit enable
  logic [1:0] txd;       // Synchronised transmit dibit
  logic       rx_go;     // Receive data request
  logic [1:0] rx_src;    // Receive data source
  logic       crs_dv;    // Receive valid out
  logic [1:0] rxd;       // Receive dibit out
  logic       rx_end;    // Pulse: receive frame ended
  logic       tx_end;    // Pulse: transmit frame ended
  logic       active;    // Traffic seen
  modport top (output ref_rise, txen, txd, rx_go, rx_src, input crs_dv, rxd, rx_end, tx_end, active);
  modport lane (input ref_rise, txen, txd, rx_go, rx_src, output crs_dv, rxd, rx_end, tx_end, active);
endinterface

/* File: src/rmii_lane.sv */
// Lane engine: moves one receive dibit per reference period, flags transmit frame end
// Assumes ref_rise and tx lanes are already synchronised to SYS_CLK
`timescale 1ns/1ps
module rmii_lane
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Lanes
  rmii_if.lane     bus
);
  logic txen_q;  // Previous transmit enable

  // One dibit per reference period while valid
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus.crs_dv <= 1'b0;
      bus.rxd    <= 2'h0;
      bus.rx_end <= 1'b0;
    end
    else
    begin
      bus.rx_end <= 1'b0;
      if (bus.ref_rise)
      begin
        bus.crs_dv <= bus.rx_go;
        bus.rxd    <= bus.rx_go ? bus.rx_src : 2'h0;
        bus.rx_end <= bus.crs_dv & ~bus.rx_go;
      end
    end
  end

  // Transmit frame end and activity
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txen_q     <= 1'b0;
      bus.tx_end <= 1'b0;
      bus.active <= 1'b0;
    end
    else
    begin
      bus.tx_end <= 1'b0;
      if (bus.ref_rise)
      begin
        txen_q     <= bus.txen;
        bus.tx_end <= txen_q & ~bus.txen;
      end
      bus.active <= bus.crs_dv | txen_q;
    end
  end

  // Receive data changes only on a reference edge
  rx_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !$past(bus.ref_rise) |-> $stable(bus.rxd)) else $error("rxd moved off edge");
endmodule

/* File: src/phy_strap_cfg.sv */
// Top: strap capture, clock mode, LED, open-drain pins, NAND tree, registers
// Assumes classic Wishbone master on SYS_CLK; pins are asynchronous
// Behaviour
// - Register 1Fh bit 7 picks reference mode
// - 25 MHz mode drives 50 MHz clock out
// - Variant parameter sets power-up clock mode
// - Receive-valid pin level latched as address
// - LED pin latched into control bits 12,13
// - Register 1Fh bits 5:4 pick LED mode
// - Management data driven open-drain, low only; here MDIO_OE is held at 0, so the pin is never driven
// - Interrupt pin open-drain, pulls low active
// - NAND-tree mode turns TXD1 into output
// - Two receive bits per valid reference period
// - Address strap gives 00011b or 00000b
// - LED strap sets autoneg 100 or forced 10
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
module phy_strap_cfg
  import phy_cfg_pkg::*;
#(
  parameter bit          CLK50_DEFAULT = 1'b0,       // Variant: 1 = 50 MHz input part
  parameter int unsigned BLINK_CYCLES  = BLINK_CYC   // Blink half period
)
(
  // System
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // Wishbone slave
  input  wire logic        WB_CYC,
  input  wire logic        WB_STB,
  input  wire logic        WB_WE,
  input  wire logic [7:0]  WB_ADR,
  input  wire logic [3:0]  WB_SEL,
  input  wire logic [31:0] WB_DAT_I,
  output logic [31:0]      WB_DAT_O,
  output logic             WB_ACK,
  // Reference clock
  input  wire logic        REF_CLK_IN,
  output logic             REF_CLK_OUT,
  output logic             REF_CLK_OE,
  // RMII
  input  wire logic        TXEN,
  input  wire logic        TXD0,
  input  wire logic        TXD1_I,
  output logic             TXD1_O,
  output logic             TXD1_OE,
  input  wire logic        CRS_DV_I,
  output logic             CRS_DV_O,
  output logic             CRS_DV_OE,
  output logic [1:0]       RXD,
  // LED and strap
  input  wire logic        LED_OUTPUT_ZERO_I,
  output logic             LED_OUTPUT_ZERO_O,
  output logic             LED_OUTPUT_ZERO_OE,
  // Management data, open drain
  input  wire logic        MDIO_I,
  output logic             MDIO_O,
  output logic             MDIO_OE,
  // Interrupt, open drain
  output logic             INT_O,
  output logic             INT_OE
);
  rmii_if lanes();  // Lane bundle

  // Synchroniser stages
  logic [1:0] ref_s_q;   // Reference clock sync
  logic [1:0] txen_s_q;  // Transmit enable sync
  logic [3:0] txd_s_q;   // Transmit dibit sync
  logic [1:0] led_s_q;   // LED strap sync
  logic [1:0] crs_s_q;   // Address strap sync
  logic [1:0] mdio_s_q;  // Management data sync
  logic       ref_q;     // Previous synced reference level

  // Two-flop synchronisers for the non-strap pins
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ref_s_q  <= 2'h0;
      txen_s_q <= 2'h0;
      txd_s_q  <= 4'h0;
      mdio_s_q <= 2'h3;
      ref_q    <= 1'b0;
    end
    else
    begin
      ref_s_q  <= {ref_s_q[0], REF_CLK_IN};
      txen_s_q <= {txen_s_q[0], TXEN};
      txd_s_q  <= {txd_s_q[1:0], TXD1_I, TXD0};
      mdio_s_q <= {mdio_s_q[0], MDIO_I};
      ref_q    <= ref_s_q[1];
    end
  end

  // Strap pin synchronisers run through reset
  // Resetting them would hide the pulled level at release
  always_ff @(posedge SYS_CLK)
  begin
    led_s_q <= {led_s_q[0], LED_OUTPUT_ZERO_I};
    crs_s_q <= {crs_s_q[0], CRS_DV_I};
  end

  // Strap capture state
  logic       strap_done_q;   // Straps taken after release
  logic [4:0] phy_address_strap_q;  // Captured address
  logic       autoneg_speed_strap_q; // Captured LED strap
  logic [15:0] basic_ctrl_q;  // Control register 0h
  logic [7:0]  phy_ctrl2_q;   // Control register 1Fh
  logic        nand_q;        // NAND-tree enable
  logic        link_q;        // Link state control
  logic [EV_W-1:0] status_q;  // Sticky events
  logic [EV_W-1:0] mask_q;    // Event mask
  logic        link_prev_q;   // Link edge detect
  logic        rd_status;     // Status read this cycle
  logic        wr_hit;        // Write accepted
  logic [EV_W-1:0] ev;        // Event pulses
  logic [31:0] basic_merge;   // Control 0h after byte merge
  logic [31:0] ctrl2_merge;   // Control 1Fh after byte merge

  // Strap latch on first clock after reset release
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      strap_done_q          <= 1'b0;
      phy_address_strap_q   <= ADDR_DOWN;
      autoneg_speed_strap_q <= 1'b1;
    end
    else if (!strap_done_q)
    begin
      strap_done_q          <= 1'b1;
      phy_address_strap_q   <= crs_s_q[1] ? ADDR_UP : ADDR_DOWN;
      autoneg_speed_strap_q <= led_s_q[1];
    end
  end

  // Write byte lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  assign basic_merge = merge({16'h0, basic_ctrl_q}, WB_DAT_I, WB_SEL);
  assign ctrl2_merge = merge({24'h0, phy_ctrl2_q}, WB_DAT_I, WB_SEL);
  assign wr_hit    = WB_CYC & WB_STB & WB_WE & ~WB_ACK;
  assign rd_status = WB_CYC & WB_STB & ~WB_WE & ~WB_ACK & (WB_ADR == OFF_STATUS);

  // Control registers; straps load control bits
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      basic_ctrl_q <= 16'h3000;
      phy_ctrl2_q  <= 8'h00;
      nand_q       <= 1'b0;
      link_q       <= 1'b0;
      mask_q       <= '0;
    end
    else if (!strap_done_q)
    begin
      // Pulled up: autoneg at 100; down: forced 10
      basic_ctrl_q[BIT_ANEN]  <= led_s_q[1];
      basic_ctrl_q[BIT_SPEED] <= led_s_q[1];
      phy_ctrl2_q[BIT_CLK50]  <= CLK50_DEFAULT;
    end
    else if (wr_hit)
    begin
      case (WB_ADR)
        OFF_BASIC_CTRL: basic_ctrl_q <= basic_merge[15:0];
        OFF_PHY_CTRL2:  phy_ctrl2_q  <= ctrl2_merge[7:0];
        OFF_MASK:       if (WB_SEL[0]) mask_q <= WB_DAT_I[EV_W-1:0];
        OFF_TEST:
          if (WB_SEL[0])
          begin
            nand_q <= WB_DAT_I[BIT_NAND];
            link_q <= WB_DAT_I[BIT_LINK];
          end
        default: ;  // Unmapped writes ignored
      endcase
    end
  end

  // Event sources
  always_comb
  begin
    ev = '0;
    ev[EV_LINK_UP]   = link_q & ~link_prev_q;
    ev[EV_LINK_DOWN] = ~link_q & link_prev_q;
    ev[EV_RX_FRAME]  = lanes.rx_end;
    ev[EV_TX_FRAME]  = lanes.tx_end;
  end

  // Sticky status, cleared by read; new event wins
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      status_q    <= '0;
      link_prev_q <= 1'b0;
    end
    else
    begin
      link_prev_q <= link_q;
      status_q    <= (rd_status ? '0 : status_q) | ev;
    end
  end

  // Wishbone answer one cycle after request
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      WB_ACK   <= 1'b0;
      WB_DAT_O <= 32'h0;
    end
    else
    begin
      WB_ACK   <= WB_CYC & WB_STB & ~WB_ACK;
      WB_DAT_O <= 32'h0;
      if (WB_CYC & WB_STB & ~WB_WE & ~WB_ACK)
      begin
        case (WB_ADR)
          OFF_BASIC_CTRL: WB_DAT_O <= {16'h0, basic_ctrl_q};
          OFF_PHY_CTRL2:  WB_DAT_O <= {24'h0, phy_ctrl2_q};
          OFF_STATUS:     WB_DAT_O <= {{(32-EV_W){1'b0}}, status_q};
          OFF_MASK:       WB_DAT_O <= {{(32-EV_W){1'b0}}, mask_q};
          OFF_STRAP:      WB_DAT_O <= {26'h0, autoneg_speed_strap_q, phy_address_strap_q};
          OFF_TEST:       WB_DAT_O <= {30'h0, link_q, nand_q};
          default:        WB_DAT_O <= 32'h0;  // Unmapped reads zero
        endcase
      end
    end
  end

  // Reference clock out: divide SYS_CLK by 4 gives 50 MHz
  logic [1:0] div_q;  // Divider
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      div_q       <= 2'h0;
      REF_CLK_OUT <= 1'b0;
      REF_CLK_OE  <= 1'b0;
    end
    else
    begin
      div_q       <= div_q + 2'h1;
      REF_CLK_OUT <= div_q[1] & ~phy_ctrl2_q[BIT_CLK50];
      REF_CLK_OE  <= ~phy_ctrl2_q[BIT_CLK50];
    end
  end

  // Reference edge: internal divider in 25 MHz mode, input pin in 50 MHz mode
  assign lanes.ref_rise = phy_ctrl2_q[BIT_CLK50] ? (ref_s_q[1] & ~ref_q) : (div_q == 2'h1);
  assign lanes.txen     = txen_s_q[1];
  assign lanes.txd      = txd_s_q[3:2];
  assign lanes.rx_go    = link_q & lanes.txen;  // Loop transmit data back as receive
  assign lanes.rx_src   = lanes.txd;

  rmii_lane u_lane
  (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .bus   (lanes)
  );

  // RMII outputs; CRS_DV stays an input until straps are taken, TXD1 until NAND-tree enable
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      CRS_DV_O  <= 1'b0;
      CRS_DV_OE <= 1'b0;
      RXD       <= 2'h0;
      TXD1_O    <= 1'b0;
      TXD1_OE   <= 1'b0;
    end
    else
    begin
      CRS_DV_O  <= lanes.crs_dv;
      CRS_DV_OE <= strap_done_q;
      RXD       <= lanes.rxd;
      TXD1_O    <= ~(txen_s_q[1] & txd_s_q[2] & led_s_q[1]);
      TXD1_OE   <= nand_q;
    end
  end

  // LED: active low, blink on activity in mode 00
  logic [31:0] blink_cnt_q;  // Blink timer
  logic        blink_q;      // Blink phase
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      blink_cnt_q <= 32'h0;
      blink_q     <= 1'b0;
      LED_OUTPUT_ZERO_O      <= 1'b1;
      LED_OUTPUT_ZERO_OE     <= 1'b0;
    end
    else
    begin
      if (blink_cnt_q >= BLINK_CYCLES - 1)
      begin
        blink_cnt_q <= 32'h0;
        blink_q     <= ~blink_q;
      end
      else
        blink_cnt_q <= blink_cnt_q + 32'h1;
      LED_OUTPUT_ZERO_OE <= strap_done_q;
      case (phy_ctrl2_q[BIT_LED_LO +: 2])
        LED_LINK_ACT: LED_OUTPUT_ZERO_O <= ~link_q | (lanes.active & blink_q);
        LED_LINK:     LED_OUTPUT_ZERO_O <= ~link_q;
        default:      LED_OUTPUT_ZERO_O <= 1'b1;  // Reserved codes: off
      endcase
    end
  end

  // Open-drain management data and interrupt
  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      MDIO_O  <= 1'b0;
      MDIO_OE <= 1'b0;
      INT_O   <= 1'b0;
      INT_OE  <= 1'b0;
    end
    else
    begin
      MDIO_O  <= 1'b0;
      MDIO_OE <= 1'b0;
      INT_O   <= 1'b0;
      INT_OE  <= |(status_q & mask_q);
    end
  end

  // Checks
  int_low_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    |(status_q & mask_q) |=> INT_OE && !INT_O) else $error("interrupt not asserted");
  int_clear_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !(|(status_q & mask_q)) |=> !INT_OE) else $error("interrupt held without event");
  mdio_od_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !MDIO_O) else $error("mdio driven high");
  refout_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    phy_ctrl2_q[BIT_CLK50] |=> !REF_CLK_OE) else $error("ref out in 50 MHz mode");
  refdrive_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    !phy_ctrl2_q[BIT_CLK50] ##1 !phy_ctrl2_q[BIT_CLK50] |-> REF_CLK_OE) else $error("ref out missing");
  nand_out_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(nand_q) |=> TXD1_OE) else $error("nand output off");
  strap_addr_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(strap_done_q) |-> phy_address_strap_q == ($past(crs_s_q[1]) ? ADDR_UP : ADDR_DOWN))
    else $error("address strap wrong");
  strap_an_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    $rose(strap_done_q) |-> basic_ctrl_q[BIT_ANEN] == $past(led_s_q[1]) && basic_ctrl_q[BIT_SPEED] == $past(led_s_q[1]))
    else $error("autoneg strap wrong");
  led_mode_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    phy_ctrl2_q[BIT_LED_LO +: 2] == LED_LINK && !link_q |=> LED_OUTPUT_ZERO_O) else $error("led on without link");
endmodule

/* File: verif/mac_model.sv */
// MAC model: reference clock source, dibit transmitter, dibit receiver
// Assumes the bench pulses send for one SYS_CLK cycle per byte
`timescale 1ns/1ps
module mac_model
(
  // Clocks
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ref_out,
  input  wire logic       ref_oe,
  output logic            ref_in,
  // Transmit side
  input  wire logic       send,
  input  wire logic [7:0] tx_byte,
  output logic            txen,
  output logic            txd0,
  output logic            txd1,
  // Receive side
  input  wire logic       crs_dv,
  input  wire logic [1:0] rxd,
  output logic [7:0]      rx_byte,
  output logic [3:0]      rx_cnt
);
  logic [2:0] ref_q;   // Reference synchroniser
  logic       ref_edge; // Reference rising edge seen
  logic [2:0] idx_q;   // Dibits sent so far
  logic       pend_q;  // Byte waiting to go

  // Free 64 ns board reference
  initial
  begin
    ref_in = 1'b0;
    forever #32 ref_in = ~ref_in;
  end

  // Follow whichever reference the device uses
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ref_q <= 3'h0;
    else
      ref_q <= {ref_q[1:0], ref_oe ? ref_out : ref_in};
  assign ref_edge = ref_q[1] & ~ref_q[2];

  // One dibit per reference period, low dibit first
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      txen   <= 1'b0;
      txd0   <= 1'b0;
      txd1   <= 1'b0;
      idx_q  <= 3'h0;
      pend_q <= 1'b0;
    end
    else
    begin
      if (send)
        pend_q <= 1'b1;
      if (ref_edge)
      begin
        if (pend_q && !txen)
        begin
          txen          <= 1'b1;
          {txd1, txd0}  <= tx_byte[1:0];
          idx_q         <= 3'h1;
          pend_q        <= 1'b0;
        end
        else if (txen && idx_q != 3'h4)
        begin
          {txd1, txd0} <= tx_byte[2*idx_q +: 2];
          idx_q        <= idx_q + 3'h1;
        end
        else
        begin
          // Released lines wander, not hold
          txen <= 1'b0;
          txd0 <= ~txd0;
          txd1 <= ~txd1;
        end
      end
    end

  // Collect received dibits while valid
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      rx_byte <= 8'h00;
      rx_cnt  <= 4'h0;
    end
    else if (ref_edge && crs_dv)
    begin
      rx_byte <= {rxd, rx_byte[7:2]};
      rx_cnt  <= rx_cnt + 4'h1;
    end
endmodule

/* File: verif/phy_strap_and_clock_config_bench.sv */
// Testbench: straps, clock modes, LED, interrupt, NAND tree, loopback
// Assumes the design under src/ and the MAC model beside this file
`timescale 1ns/1ps
module phy_strap_and_clock_config_bench import phy_cfg_pkg::*;;
  logic        SYS_CLK, RESET_N, WB_CYC, WB_STB, WB_WE, WB_ACK;
  logic [7:0]  WB_ADR;
  logic [3:0]  WB_SEL;
  logic [31:0] WB_DAT_I, WB_DAT_O, rd;
  logic        REF_CLK_IN, REF_CLK_OUT, REF_CLK_OE, TXEN, TXD0, TXD1_I, TXD1_O, TXD1_OE;
  logic        CRS_DV_I, CRS_DV_O, CRS_DV_OE, LED_OUTPUT_ZERO_I, LED_OUTPUT_ZERO_O, LED_OUTPUT_ZERO_OE;
  logic        MDIO_I, MDIO_O, MDIO_OE, INT_O, INT_OE, int_pin, mac_txd1;
  logic [1:0]  RXD;
  logic        strap_crs, strap_led, send;
  logic [7:0]  tx_byte, rx_byte;
  logic [3:0]  rx_cnt, c0;
  int          failures, tests_run, n;

  // Pin levels from all drivers and pulls
  assign CRS_DV_I = CRS_DV_OE ? CRS_DV_O : strap_crs;
  assign LED_OUTPUT_ZERO_I   = LED_OUTPUT_ZERO_OE ? LED_OUTPUT_ZERO_O : strap_led;
  assign MDIO_I   = (MDIO_OE && !MDIO_O) ? 1'b0 : 1'b1;
  assign TXD1_I   = TXD1_OE ? TXD1_O : mac_txd1;
  assign int_pin  = INT_OE ? INT_O : 1'b1;

  phy_strap_cfg #(.CLK50_DEFAULT(1'b0), .BLINK_CYCLES(8)) i_dut
  (.SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_WE(WB_WE),
   .WB_ADR(WB_ADR), .WB_SEL(WB_SEL), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK(WB_ACK),
   .REF_CLK_IN(REF_CLK_IN), .REF_CLK_OUT(REF_CLK_OUT), .REF_CLK_OE(REF_CLK_OE), .TXEN(TXEN),
   .TXD0(TXD0), .TXD1_I(TXD1_I), .TXD1_O(TXD1_O), .TXD1_OE(TXD1_OE), .CRS_DV_I(CRS_DV_I),
   .CRS_DV_O(CRS_DV_O), .CRS_DV_OE(CRS_DV_OE), .RXD(RXD), .LED_OUTPUT_ZERO_I(LED_OUTPUT_ZERO_I), .LED_OUTPUT_ZERO_O(LED_OUTPUT_ZERO_O),
   .LED_OUTPUT_ZERO_OE(LED_OUTPUT_ZERO_OE), .MDIO_I(MDIO_I), .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE), .INT_O(INT_O), .INT_OE(INT_OE));

  mac_model i_mac
  (.clk(SYS_CLK), .rst_n(RESET_N), .ref_out(REF_CLK_OUT), .ref_oe(REF_CLK_OE), .ref_in(REF_CLK_IN),
   .send(send), .tx_byte(tx_byte), .txen(TXEN), .txd0(TXD0), .txd1(mac_txd1), .crs_dv(CRS_DV_O),
   .rxd(RXD), .rx_byte(rx_byte), .rx_cnt(rx_cnt));

  // 200 MHz system clock
  initial
  begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end

  // Compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic Wishbone cycle
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge SYS_CLK);
    WB_CYC   <= 1'b1;
    WB_STB   <= 1'b1;
    WB_WE    <= we;
    WB_ADR   <= a;
    WB_DAT_I <= d;
    k = 0;
    do
    begin
      @(posedge SYS_CLK);
      k++;
    end
    while (WB_ACK !== 1'b1 && k < 50);
    rd = WB_DAT_O;
    if (k >= 50)
      failures++;
    WB_CYC <= 1'b0;
    WB_STB <= 1'b0;
    WB_WE  <= 1'b0;
  endtask

  // Reset with given strap pulls
  task automatic do_reset(input logic a, input logic l);
    @(posedge SYS_CLK);
    RESET_N   <= 1'b0;
    strap_crs <= a;
    strap_led <= l;
    repeat (16) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
  endtask

  // Reference output rises in 40 cycles
  task automatic rises(input int exp);
    logic p;
    int   r;
    p = REF_CLK_OUT;
    r = 0;
    repeat (40)
    begin
      @(posedge SYS_CLK);
      if (REF_CLK_OUT && !p)
        r++;
      p = REF_CLK_OUT;
    end
    chk("ref_rises", r, exp);
  endtask

  // Verdict
  task automatic report_and_stop;
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge SYS_CLK);
    failures++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    failures = 0;
    tests_run = 0;
    RESET_N = 1'b0;
    {WB_CYC, WB_STB, WB_WE, send} = 4'h0;
    WB_ADR = 8'h00;
    WB_SEL = 4'hF;
    WB_DAT_I = 32'h0;
    {strap_crs, strap_led} = 2'h3;
    tx_byte = 8'hA5;
    do_reset(1'b1, 1'b1);
    wb(1'b0, OFF_STRAP, 32'h0);
    chk("strap_up", rd, {26'h0, 1'b1, ADDR_UP});
    wb(1'b0, OFF_BASIC_CTRL, 32'h0);
    chk("autoneg_speed_strap_up", rd & 32'h0000_3000, 32'h0000_3000);
    wb(1'b0, OFF_PHY_CTRL2, 32'h0);
    chk("mode_reset", rd & 32'h0000_00B0, 32'h0);
    chk("ref_oe_25", REF_CLK_OE, 1'b1);
    rises(10);
    chk("mdio_oe", MDIO_OE, 1'b0);
    chk("mdio_pin", MDIO_I, 1'b1);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", rd, 32'h0);
    // Switch to 50 MHz input and back
    wb(1'b1, OFF_PHY_CTRL2, 32'h0000_0080);
    repeat (4) @(posedge SYS_CLK);
    chk("ref_oe_50", REF_CLK_OE, 1'b0);
    rises(0);
    wb(1'b1, OFF_PHY_CTRL2, 32'h0);
    repeat (4) @(posedge SYS_CLK);
    rises(10);
    // Link up with unmasked event
    wb(1'b1, OFF_MASK, 32'hF);
    wb(1'b1, OFF_TEST, 32'h2);
    repeat (4) @(posedge SYS_CLK);
    chk("int_low", int_pin, 1'b0);
    chk("led_link_act", LED_OUTPUT_ZERO_O, 1'b0);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk("status_up", rd, 32'h1);
    repeat (2) @(posedge SYS_CLK);
    chk("int_release", int_pin, 1'b1);
    // Masked link down, then link-only LED mode
    wb(1'b1, OFF_MASK, 32'h0);
    wb(1'b1, OFF_TEST, 32'h0);
    repeat (4) @(posedge SYS_CLK);
    chk("int_masked", int_pin, 1'b1);
    chk("led_off", LED_OUTPUT_ZERO_O, 1'b1);
    wb(1'b1, OFF_PHY_CTRL2, {26'h0, LED_LINK, 4'h0});
    wb(1'b0, OFF_PHY_CTRL2, 32'h0);
    chk("led_mode", rd[5:4], LED_LINK);
    wb(1'b1, OFF_TEST, 32'h2);
    repeat (4) @(posedge SYS_CLK);
    chk("led_link", LED_OUTPUT_ZERO_O, 1'b0);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk("status_down_up", rd, 32'h3);
    // Loopback of two bytes
    foreach (tx_byte[i])
      if (i < 2)
      begin
        tx_byte <= (i == 0) ? 8'hA5 : 8'h3C;
        c0 = rx_cnt;
        @(posedge SYS_CLK);
        send <= 1'b1;
        @(posedge SYS_CLK);
        send <= 1'b0;
        n = 0;
        while (rx_cnt !== c0 + 4'h4 && n < 300)
        begin
          @(posedge SYS_CLK);
          n++;
        end
        repeat (30) @(posedge SYS_CLK);
        chk("rx_dibits", {28'h0, rx_cnt - c0}, 32'h4);
        chk("rx_byte", rx_byte, (i == 0) ? 8'hA5 : 8'h3C);
      end
    wb(1'b0, OFF_STATUS, 32'h0);
    chk("status_frames", rd, 32'hC);
    // NAND tree output
    wb(1'b1, OFF_TEST, 32'h1);
    repeat (3) @(posedge SYS_CLK);
    chk("nand_oe", TXD1_OE, 1'b1);
    chk("nand_out", TXD1_O, 1'b1);
    wb(1'b1, OFF_TEST, 32'h0);
    repeat (3) @(posedge SYS_CLK);
    chk("nand_off", TXD1_OE, 1'b0);
    // Second reset with straps pulled down
    do_reset(1'b0, 1'b0);
    wb(1'b0, OFF_STRAP, 32'h0);
    chk("strap_down", rd, {26'h0, 1'b0, ADDR_DOWN});
    wb(1'b0, OFF_BASIC_CTRL, 32'h0);
    chk("autoneg_speed_strap_down", rd & 32'h0000_3000, 32'h0);
    report_and_stop();
  end
endmodule
